// ==== core/np_ext_ctrl.v ====
// next page transmit and extended control registers with tx/rx options
`timescale 1ns/1ps
`include "np_ext_consts.vh"

module np_ext_ctrl (
  input wire sys_clk,
  input wire rst, // hardware / power-on reset
  input wire sw_reset, // software reset pulse
  input wire mdc,
  input wire mdio_in,
  output wire mdio_out,
  output wire mdio_oe_n,
  input wire addr0_led_pin,
  input wire addr1_led_pin,
  input wire addr2_led_pin,
  input wire addr3_led_pin,
  input wire addr4_led_pin,
  input wire base_bit11, // bit 11 of base link code word
  input wire np_sent, // pulse: a next page word went out
  input wire np_restart, // pulse: negotiation restarted
  output reg [15:0] np_word_reg, // outgoing next page word
  output reg override_en_reg, // override window for the protected scrambler-disable bit
  input wire speed_100,
  input wire tx_nib_valid,
  input wire [3:0] tx_nibble,
  input wire tx_er,
  output reg [4:0] tx_code_reg, // 5-bit code group
  input wire tx_bit_valid,
  input wire tx_bit_in, // serial code stream
  output reg tx_line_reg, // encoded serial line bit
  output reg descr_unlock_reg, // force descrambler out of lock
  output reg descr_bypass_reg // receive descrambler bypassed
);

  // -----------------------------------------------------------------
  // register storage
  // -----------------------------------------------------------------
  wire [4:0] reg_addr; // address of current write or read
  wire [15:0] wr_data;
  wire wr_req; // one-cycle write strobe
  reg [15:0] rd_mux; // read data for the frame engine
  reg [4:0] phy_addr_reg; // latched port address
  reg more_pages_flag_reg;
  reg message_page_flag_reg;
  reg can_comply_flag_reg;
  reg [10:0] code_reg; // message / unformatted code field
  reg test_mode_reg; // scrambler test mode
  reg nrzi_reg; // 1 nrzi, 0 nrz
  reg inv_code_reg; // invalid-code transmit enable
  reg scr_dis_reg; // scrambler disable, override protected
  reg last_toggle_reg; // toggle of previously sent page
  reg sent_any_reg; // a page has gone out since restart
  reg [10:0] lfsr_reg; // transmit scrambler state
  wire toggle_cur; // toggle for page about to go out
  wire wr_np;
  wire wr_ext;
  wire scr_bypass;
  wire scr_bit;
  wire [4:0] nib_code;

  assign wr_np = wr_req & (reg_addr == `NP_TX_ADDR);
  assign wr_ext = wr_req & (reg_addr == `EXT_CTRL_ADDR);
  // bypass only means something at 100 mb/s
  assign scr_bypass = scr_dis_reg & speed_100; // RL15

  // -----------------------------------------------------------------
  // frame engine on the management pins
  // -----------------------------------------------------------------
  mgmt_frame u_frame (
    .sys_clk(sys_clk),
    .rst(rst),
    .mdc(mdc),
    .mdio_in(mdio_in),
    .mdio_out(mdio_out),
    .mdio_oe_n(mdio_oe_n),
    .phy_addr(phy_addr_reg),
    .rd_data(rd_mux),
    .reg_addr(reg_addr),
    .wr_data(wr_data),
    .wr_req(wr_req)
  );

  // -----------------------------------------------------------------
  // port address latch
  // -----------------------------------------------------------------
  // sampled every cycle of hard reset, frozen from its release on;
  // sw_reset and management writes never reach it
  always @(posedge sys_clk) begin
    if (rst) begin
      phy_addr_reg <= {addr4_led_pin, addr3_led_pin, addr2_led_pin,
                       addr1_led_pin, addr0_led_pin}; // RL10
    end
  end // RL11 RL17

  // -----------------------------------------------------------------
  // next page transmit register
  // -----------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (rst | sw_reset) begin
      more_pages_flag_reg <= 1'b0;
      message_page_flag_reg <= 1'b1;
      can_comply_flag_reg <= 1'b0;
      code_reg <= `NP_CODE_RST;
    end else if (wr_np) begin
      // reserved bit 14 and device-owned toggle are not stored
      more_pages_flag_reg <= wr_data[`NP_MORE_BIT];
      message_page_flag_reg <= wr_data[`NP_MSG_BIT];
      can_comply_flag_reg <= wr_data[`NP_CAN_COMPLY_FLAG_BIT];
      code_reg <= wr_data[`NP_CODE_MSB:0];
    end
  end

  // -----------------------------------------------------------------
  // toggle tracking across successive next pages
  // -----------------------------------------------------------------
  assign toggle_cur = sent_any_reg ? ~last_toggle_reg : ~base_bit11; // RL5 RL6

  always @(posedge sys_clk) begin
    if (rst | sw_reset | np_restart) begin
      sent_any_reg <= 1'b0;
      last_toggle_reg <= 1'b0;
    end else if (np_sent) begin
      sent_any_reg <= 1'b1;
      last_toggle_reg <= toggle_cur; // RL5
    end
  end

  // outgoing word rebuilt each cycle so it follows register writes
  always @(posedge sys_clk) begin
    if (rst) begin
      np_word_reg <= 16'h0000;
    end else begin
      np_word_reg <= {more_pages_flag_reg, 1'b0,
                      message_page_flag_reg, // RL3
                      can_comply_flag_reg, // RL4
                      toggle_cur,
                      code_reg}; // RL7
    end
  end

  // -----------------------------------------------------------------
  // extended control register
  // -----------------------------------------------------------------
  // the write that opens the override window does not itself pass
  // protected bits; only the following write does
  always @(posedge sys_clk) begin
    if (rst | sw_reset) begin
      override_en_reg <= 1'b0;
      test_mode_reg <= 1'b0;
      nrzi_reg <= `EXT_NRZI_RST; // RL13
      inv_code_reg <= 1'b0;
      scr_dis_reg <= 1'b0;
    end else begin
      if (wr_req) begin
        // any write closes the window; reg16 may reopen it
        override_en_reg <= wr_ext & wr_data[`EXT_OVR_BIT]; // RL8 RL9
      end
      if (wr_ext) begin
        test_mode_reg <= wr_data[`EXT_TEST_BIT];
        nrzi_reg <= wr_data[`EXT_NRZI_BIT];
        inv_code_reg <= wr_data[`EXT_INV_BIT];
        if (override_en_reg) begin
          scr_dis_reg <= wr_data[`EXT_SCR_BIT]; // RL8
        end // RL16
      end
    end
  end

  // -----------------------------------------------------------------
  // read mux, reserved bits forced low
  // -----------------------------------------------------------------
  always @* begin
    case (reg_addr)
      `NP_TX_ADDR: begin
        rd_mux = {more_pages_flag_reg, 1'b0, message_page_flag_reg,
                  can_comply_flag_reg, toggle_cur, code_reg}; // RL1
      end
      `EXT_CTRL_ADDR: begin
        rd_mux = {override_en_reg, 4'h0, phy_addr_reg, test_mode_reg,
                  1'b0, nrzi_reg, inv_code_reg, 1'b0, scr_dis_reg}; // RL1
      end
      default: begin
        rd_mux = 16'h0000; // unmapped here: reads as zero
      end
    endcase
  end

  // -----------------------------------------------------------------
  // nibble to code-group translation
  // -----------------------------------------------------------------
  function [4:0] enc_normal;
    input [3:0] n;
    begin
      case (n)
        4'h0: enc_normal = 5'h1e;
        4'h1: enc_normal = 5'h09;
        4'h2: enc_normal = 5'h14;
        4'h3: enc_normal = 5'h15;
        4'h4: enc_normal = 5'h0a;
        4'h5: enc_normal = 5'h0b;
        4'h6: enc_normal = 5'h0e;
        4'h7: enc_normal = 5'h0f;
        4'h8: enc_normal = 5'h12;
        4'h9: enc_normal = 5'h13;
        4'ha: enc_normal = 5'h16;
        4'hb: enc_normal = 5'h17;
        4'hc: enc_normal = 5'h1a;
        4'hd: enc_normal = 5'h1b;
        4'he: enc_normal = 5'h1c;
        default: enc_normal = 5'h1d;
      endcase
    end
  endfunction

  // test table: produces groups the normal mapping never emits
  function [4:0] enc_invalid;
    input [3:0] n;
    begin
      case (n)
        4'h8: enc_invalid = 5'h00;
        4'h9: enc_invalid = 5'h0d;
        4'ha: enc_invalid = 5'h0c;
        4'hb: enc_invalid = 5'h11;
        4'hc: enc_invalid = 5'h10;
        4'hd: enc_invalid = 5'h19;
        4'he: enc_invalid = 5'h18;
        4'hf: enc_invalid = 5'h1f;
        default: enc_invalid = {1'b0, n};
      endcase
    end
  endfunction

  assign nib_code = (inv_code_reg & tx_er) ? enc_invalid(tx_nibble) : enc_normal(tx_nibble); // RL14

  always @(posedge sys_clk) begin
    if (rst) begin
      tx_code_reg <= 5'h1f;
    end else if (tx_nib_valid) begin
      tx_code_reg <= nib_code; // RL14
    end
  end

  // -----------------------------------------------------------------
  // serial scrambler and line coding
  // -----------------------------------------------------------------
  // x^11 + x^9 + 1 keystream; lfsr keeps running when bypassed so
  // re-enabling needs no re-seed
  assign scr_bit = scr_bypass ? tx_bit_in : (tx_bit_in ^ lfsr_reg[10]); // RL15

  always @(posedge sys_clk) begin
    if (rst) begin
      lfsr_reg <= 11'h7ff;
      tx_line_reg <= 1'b0;
    end else if (tx_bit_valid) begin
      lfsr_reg <= {lfsr_reg[9:0], lfsr_reg[10] ^ lfsr_reg[8]};
      if (nrzi_reg) begin
        tx_line_reg <= tx_line_reg ^ scr_bit; // RL13
      end else begin
        tx_line_reg <= scr_bit; // RL13
      end
    end
  end

  // -----------------------------------------------------------------
  // receive descrambler controls
  // -----------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (rst) begin
      descr_unlock_reg <= 1'b0;
      descr_bypass_reg <= 1'b0;
    end else begin
      descr_unlock_reg <= test_mode_reg; // RL12
      descr_bypass_reg <= scr_bypass; // RL15
    end
  end

endmodule // np_ext_ctrl

// ==== core/np_ext_consts.vh ====
// constants for the next-page and extended control register block
// Functional notes
// [RL1] reserved bits always read back as zero
// [RL2] manager writes reserved bits at default value
// [RL3] message page bit copied into outgoing page
// [RL4] can-comply bit copied into outgoing page
// [RL5] toggle inverts on every next page sent
// [RL6] first toggle is inverse base word bit 11
// [RL7] low eleven bits copied into code field
// [RL8] override enable, then one write alters protected bits
// [RL9] override enable clears after next write
// [RL10] hard reset latches port address from pins
// [RL11] software reset keeps latched port address
// [RL12] scrambler test mode forces descrambler out of lock
// [RL13] encoding select: zero nrz, one nrzi, reset one
// [RL14] invalid-code enable with tx error uses fixed table
// [RL15] scrambler disable bypasses both directions at 100m
// [RL16] protected bit unchanged without override enable
// [RL17] writes to port address bits are ignored
`ifndef NP_EXT_CONSTS_VH
`define NP_EXT_CONSTS_VH

// -----------------------------------------------------------------
// register addresses
// -----------------------------------------------------------------
`define NP_TX_ADDR 5'h08
`define EXT_CTRL_ADDR 5'h10

// -----------------------------------------------------------------
// next page transmit register fields
// -----------------------------------------------------------------
`define NP_MORE_BIT 15
`define NP_MSG_BIT 13
`define NP_CAN_COMPLY_FLAG_BIT 12
`define NP_TOGGLE_BIT 11
`define NP_CODE_MSB 10

// -----------------------------------------------------------------
// extended control register fields, reset values of both registers
// -----------------------------------------------------------------
`define EXT_OVR_BIT 15
`define EXT_ADDR_MSB 10
`define EXT_ADDR_LSB 6
`define EXT_TEST_BIT 5
`define EXT_NRZI_BIT 3
`define EXT_INV_BIT 2
`define EXT_SCR_BIT 0
`define EXT_NRZI_RST 1'b1
`define NP_CODE_RST 11'h001

// -----------------------------------------------------------------
// management frame timing, in management clock bits, and read / write opcodes
// -----------------------------------------------------------------
`define MGMT_PRE_BITS 5'h1f
`define MGMT_HDR_BITS 5'h0d
`define MGMT_DATA_BITS 5'h10
`define MGMT_OP_RD 2'h2
`define MGMT_OP_WR 2'h1

`endif

// ==== core/mgmt_frame.v ====
// serial management frame engine: decodes frames, drives read data
`timescale 1ns/1ps
`include "np_ext_consts.vh"

module mgmt_frame (
  input wire sys_clk,
  input wire rst,
  input wire mdc, // management clock, sampled as a data input
  input wire mdio_in,
  output reg mdio_out,
  output reg mdio_oe_n, // low while this end drives the line
  input wire [4:0] phy_addr, // latched port address
  input wire [15:0] rd_data, // read mux, sampled on the second turnaround rise
  output reg [4:0] reg_addr,
  output reg [15:0] wr_data,
  output reg wr_req // one-cycle write strobe
);

  // -----------------------------------------------------------------
  // frame states
  // -----------------------------------------------------------------
  localparam S_PRE = 2'd0;
  localparam S_HDR = 2'd1;
  localparam S_TA = 2'd2;
  localparam S_DAT = 2'd3;

  reg mdc_reg; // previous mdc level for edge detect
  reg [1:0] state_reg;
  reg [4:0] cnt_reg; // bit counter within a field
  reg [15:0] sh_reg; // header / data shift register
  reg is_rd_reg; // frame is a read aimed at this port
  reg is_wr_reg; // frame is a write aimed at this port
  wire rise;
  wire hdr_rd;
  wire hdr_wr;

  assign rise = mdc & ~mdc_reg;
  // thirteen header bits land in [12:0]: st1, op[1:0], phy[4:0], reg[4:0]
  assign hdr_rd = sh_reg[12] & (sh_reg[11:10] == `MGMT_OP_RD) & (sh_reg[9:5] == phy_addr);
  assign hdr_wr = sh_reg[12] & (sh_reg[11:10] == `MGMT_OP_WR) & (sh_reg[9:5] == phy_addr);

  // -----------------------------------------------------------------
  // frame sequencer, advances on each rising management clock
  // -----------------------------------------------------------------
  always @(posedge sys_clk) begin
    wr_req <= 1'b0;
    if (rst) begin
      mdc_reg <= 1'b0;
      state_reg <= S_PRE;
      cnt_reg <= 5'h00;
      sh_reg <= 16'h0000;
      is_rd_reg <= 1'b0;
      is_wr_reg <= 1'b0;
      reg_addr <= 5'h00;
      wr_data <= 16'h0000;
      mdio_out <= 1'b1;
      mdio_oe_n <= 1'b1;
    end else begin
      mdc_reg <= mdc;
      if (rise) begin
        case (state_reg)
          S_PRE: begin
            // count ones; a zero after a full preamble starts a frame
            if (mdio_in) begin
              if (cnt_reg != `MGMT_PRE_BITS) begin
                cnt_reg <= cnt_reg + 5'h01;
              end
            end else if (cnt_reg == `MGMT_PRE_BITS) begin
              state_reg <= S_HDR;
              cnt_reg <= 5'h00;
            end else begin
              cnt_reg <= 5'h00;
            end
          end
          S_HDR: begin
            sh_reg <= {sh_reg[14:0], mdio_in};
            cnt_reg <= cnt_reg + 5'h01;
            if (cnt_reg == `MGMT_HDR_BITS - 5'h01) begin
              state_reg <= S_TA;
              cnt_reg <= 5'h00;
            end
          end
          S_TA: begin
            if (cnt_reg == 5'h00) begin
              // decode header once complete
              is_rd_reg <= hdr_rd;
              is_wr_reg <= hdr_wr;
              reg_addr <= sh_reg[4:0];
              cnt_reg <= 5'h01;
              if (hdr_rd) begin
                mdio_out <= 1'b0; // second turnaround bit
                mdio_oe_n <= 1'b0;
              end
            end else begin
              state_reg <= S_DAT;
              cnt_reg <= 5'h00;
              if (is_rd_reg) begin
                sh_reg <= {rd_data[14:0], 1'b0};
                mdio_out <= rd_data[15];
              end
            end
          end
          S_DAT: begin
            cnt_reg <= cnt_reg + 5'h01;
            if (is_rd_reg) begin
              mdio_out <= sh_reg[15];
              sh_reg <= {sh_reg[14:0], 1'b0};
            end else begin
              sh_reg <= {sh_reg[14:0], mdio_in};
            end
            if (cnt_reg == `MGMT_DATA_BITS - 5'h01) begin
              // frame done: release line, post a write
              state_reg <= S_PRE;
              cnt_reg <= 5'h00;
              mdio_out <= 1'b1;
              mdio_oe_n <= 1'b1;
              if (is_wr_reg) begin
                wr_data <= {sh_reg[14:0], mdio_in};
                wr_req <= 1'b1;
              end
            end
          end
          default: begin
            state_reg <= S_PRE;
          end
        endcase
      end
    end
  end

endmodule // mgmt_frame

// ==== tb/np_ext_ctrl_sva.sv ====
// assertion checker for the next-page and extended control block
`timescale 1ns/1ps

module np_ext_ctrl_sva (
  input wire sys_clk,
  input wire rst,
  input wire sw_reset,
  input wire mdio_out,
  input wire mdio_oe_n,
  input wire base_bit11,
  input wire np_sent,
  input wire np_restart,
  input wire [15:0] np_word_reg,
  input wire override_en_reg,
  input wire speed_100,
  input wire tx_nib_valid,
  input wire tx_er,
  input wire [4:0] tx_code_reg,
  input wire tx_bit_valid,
  input wire tx_line_reg,
  input wire descr_bypass_reg
);
  // ---------------------------------------------------------------
  // properties, all in the one clock domain
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  // software reset also resets toggle history and control bits
  default disable iff (rst || sw_reset);

  reset_vals_a: assert property (disable iff (1'b0) rst |=> !override_en_reg && mdio_oe_n && mdio_out &&
    tx_code_reg == 5'h1f && !descr_bypass_reg) else $error("outputs wrong after reset");
  toggle_flip_a: assert property (np_sent && !np_restart |=> ##1 np_word_reg[11] != $past(np_word_reg[11]))
    else $error("toggle did not invert after a page");
  first_toggle_a: assert property (np_restart && !np_sent |=> ##1 np_word_reg[11] == !$past(base_bit11))
    else $error("first toggle not inverse of base bit");
  np_reserved_a: assert property (!np_word_reg[14]) else $error("reserved page bit set");
  bypass_speed_a: assert property (descr_bypass_reg |-> $past(speed_100))
    else $error("bypass active outside 100m");
  ovr_hold_a: assert property ($rose(override_en_reg) |-> override_en_reg [*8])
    else $error("override window collapsed early");
  code_update_a: assert property ($changed(tx_code_reg) |-> $past(tx_nib_valid))
    else $error("code group moved without a nibble");
  line_update_a: assert property ($changed(tx_line_reg) |-> $past(tx_bit_valid))
    else $error("line bit moved without an input bit");
  ta_zero_a: assert property ($fell(mdio_oe_n) |-> !mdio_out) else $error("turnaround bit not zero");
  drive_hold_a: assert property ($fell(mdio_oe_n) |-> !mdio_oe_n [*8]) else $error("read drive dropped early");

  // ---------------------------------------------------------------
  // main scenarios seen
  // ---------------------------------------------------------------
  cover property (np_sent);
  cover property ($fell(mdio_oe_n));
  cover property ($rose(override_en_reg));
  cover property (tx_er && tx_nib_valid);
endmodule // np_ext_ctrl_sva

bind np_ext_ctrl np_ext_ctrl_sva i_np_ext_ctrl_sva (.sys_clk(sys_clk), .rst(rst), .sw_reset(sw_reset),
  .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .base_bit11(base_bit11), .np_sent(np_sent),
  .np_restart(np_restart), .np_word_reg(np_word_reg), .override_en_reg(override_en_reg),
  .speed_100(speed_100), .tx_nib_valid(tx_nib_valid), .tx_er(tx_er), .tx_code_reg(tx_code_reg),
  .tx_bit_valid(tx_bit_valid), .tx_line_reg(tx_line_reg), .descr_bypass_reg(descr_bypass_reg));

// ==== tb/mgmt_station.sv ====
// station management model that drives serial management frames
`timescale 1ns/1ps

module mgmt_station (
  input wire sys_clk,
  input wire line, // resolved level of the shared data wire
  output reg mdc,
  output reg drv, // value this end puts on the wire
  output reg drv_oe // high while this end drives
);
  // ---------------------------------------------------------------
  // bit and frame tasks
  // ---------------------------------------------------------------
  // clock parks low between frames, wire released to its pull-up
  initial begin
    mdc = 1'b0;
    drv = 1'b1;
    drv_oe = 1'b0;
  end

  // one bit period of eight clocks; sample just before the rise
  task tick(input b, input oe, output s);
    begin
      @(posedge sys_clk);
      mdc <= 1'b0;
      drv <= b;
      drv_oe <= oe;
      repeat (4) @(posedge sys_clk);
      s = line;
      mdc <= 1'b1;
      repeat (3) @(posedge sys_clk);
    end
  endtask

  // full frame; callers keep reserved bits at default in wd
  task frame(input [1:0] op, input [4:0] phy, input [4:0] ra, input [15:0] wd, output [15:0] rd);
    integer i;
    reg s;
    reg [47:0] hdr;
    begin
      hdr = {32'hffffffff, 2'b01, op, phy, ra, 2'b10};
      for (i = 47; i >= 0; i = i - 1)
        tick(hdr[i], !(op == 2'h2 && i < 2), s);
      for (i = 15; i >= 0; i = i - 1) begin
        tick(wd[i], op != 2'h2, s);
        rd[i] = s;
      end
      @(posedge sys_clk);
      mdc <= 1'b0;
      drv_oe <= 1'b0;
    end
  endtask
endmodule // mgmt_station

// ==== tb/next_page_and_extended_control_regs_bench.sv ====
// self-checking bench for the next-page and extended control block
`timescale 1ns/1ps

module next_page_and_extended_control_regs_bench;
  // ---------------------------------------------------------------
  // stimulus, wires and bookkeeping
  // ---------------------------------------------------------------
  reg sys_clk, rst, sw_reset, base_bit11, np_sent, np_restart, speed_100;
  reg tx_nib_valid, tx_er, tx_bit_valid, tx_bit_in, lvl;
  reg [3:0] tx_nibble;
  reg [4:0] pins, phy; // strap pins and the address we expect latched
  reg [15:0] rd;
  reg [3:0] pat; // serial test pattern, msb first
  reg [39:0] rows [0:4]; // register, write value, read value without address
  wire mdc, mdio_out, mdio_oe_n, drv, drv_oe, override_en_reg, tx_line_reg, descr_unlock_reg, descr_bypass_reg;
  wire [15:0] np_word_reg;
  wire [4:0] tx_code_reg;
  // undriven wire floats to its pull-up
  wire line = !mdio_oe_n ? mdio_out : (drv_oe ? drv : 1'b1);
  integer n_fail = 0, n_tests = 0, i;
  localparam [79:0] inv_tab = {5'h1f, 5'h18, 5'h19, 5'h10, 5'h11, 5'h0c, 5'h0d, 5'h00,
    5'h07, 5'h06, 5'h05, 5'h04, 5'h03, 5'h02, 5'h01, 5'h00};

  np_ext_ctrl i_np_ext_ctrl (.sys_clk(sys_clk), .rst(rst), .sw_reset(sw_reset), .mdc(mdc), .mdio_in(line),
    .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .addr0_led_pin(pins[0]), .addr1_led_pin(pins[1]),
    .addr2_led_pin(pins[2]), .addr3_led_pin(pins[3]), .addr4_led_pin(pins[4]), .base_bit11(base_bit11),
    .np_sent(np_sent), .np_restart(np_restart), .np_word_reg(np_word_reg), .override_en_reg(override_en_reg),
    .speed_100(speed_100), .tx_nib_valid(tx_nib_valid), .tx_nibble(tx_nibble), .tx_er(tx_er),
    .tx_code_reg(tx_code_reg), .tx_bit_valid(tx_bit_valid), .tx_bit_in(tx_bit_in), .tx_line_reg(tx_line_reg),
    .descr_unlock_reg(descr_unlock_reg), .descr_bypass_reg(descr_bypass_reg));
  mgmt_station i_mgmt_station (.sys_clk(sys_clk), .line(line), .mdc(mdc), .drv(drv), .drv_oe(drv_oe));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task check(input [15:0] seen, input [15:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  // write, then let the register settle
  task wr(input [4:0] ra, input [15:0] d);
    begin
      i_mgmt_station.frame(2'h1, phy, ra, d, rd);
      repeat (4) @(posedge sys_clk);
    end
  endtask
  // read and compare; the address field is added for register 0x10
  task rdr(input [4:0] ra, input [15:0] exp);
    begin
      i_mgmt_station.frame(2'h2, phy, ra, 16'h0000, rd);
      check(rd, exp | ((ra == 5'h10) ? {5'h00, phy, 6'h00} : 16'h0000));
    end
  endtask
  task pulse_sent;
    begin
      np_sent <= 1'b1;
      @(posedge sys_clk);
      np_sent <= 1'b0;
      repeat (3) @(posedge sys_clk);
    end
  endtask
  // one serial bit through the line encoder
  task feed(input b, input exp);
    begin
      tx_bit_in <= b;
      tx_bit_valid <= 1'b1;
      @(posedge sys_clk);
      tx_bit_valid <= 1'b0;
      @(posedge sys_clk);
      check({15'h0000, tx_line_reg}, {15'h0000, exp});
    end
  endtask
  task wrap_up;
    begin
      $display("tests %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst = 1'b1; sw_reset = 1'b0; base_bit11 = 1'b0; np_sent = 1'b0; np_restart = 1'b0; speed_100 = 1'b1;
    tx_nib_valid = 1'b0; tx_er = 1'b0; tx_bit_valid = 1'b0; tx_bit_in = 1'b0; tx_nibble = 4'h0;
    pins = 5'h0b; phy = 5'h0b;
    rows[0] = {8'h10, 16'h0029, 16'h0028};
    rows[1] = {8'h10, 16'h07c4, 16'h0004};
    rows[2] = {8'h08, 16'hb7ff, 16'hbfff};
    rows[3] = {8'h08, 16'h0400, 16'h0c00};
    rows[4] = {8'h05, 16'hffff, 16'h0000};
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rdr(5'h10, 16'h0008);
    rdr(5'h08, 16'h2801);
    check(np_word_reg, 16'h2801);
    $display("reset values done");
    // ordinary register rows; reserved bits kept at default, read-only bits hit
    for (i = 0; i < 5; i = i + 1) begin
      wr(rows[i][36:32], rows[i][31:16]);
      rdr(rows[i][36:32], rows[i][15:0]);
      if (rows[i][39:32] == 8'h08) check(np_word_reg, rows[i][15:0]);
    end
    $display("register rows done");
    // invalid-code table with the enable left set by the rows
    tx_er <= 1'b1;
    for (i = 0; i < 16; i = i + 1) begin
      tx_nibble <= i[3:0];
      tx_nib_valid <= 1'b1;
      @(posedge sys_clk);
      tx_nib_valid <= 1'b0;
      @(posedge sys_clk);
      check({11'h000, tx_code_reg}, {11'h000, inv_tab[i*5 +: 5]});
    end
    tx_er <= 1'b0;
    $display("invalid codes done");
    // two-step override, then a refused change of the protected bit
    wr(5'h10, 16'h8004);
    check({15'h0000, override_en_reg}, 16'h0001);
    wr(5'h10, 16'h0005);
    check({15'h0000, override_en_reg}, 16'h0000);
    rdr(5'h10, 16'h0005);
    check({15'h0000, descr_bypass_reg}, 16'h0001);
    pat = 4'b1011;
    for (i = 3; i >= 0; i = i - 1) feed(pat[i], pat[i]);
    wr(5'h10, 16'h0008);
    rdr(5'h10, 16'h0009);
    pat = 4'b1101;
    lvl = 1'b1;
    for (i = 3; i >= 0; i = i - 1) begin
      lvl = lvl ^ pat[i];
      feed(pat[i], lvl);
    end
    wr(5'h10, 16'h0029);
    check({15'h0000, descr_unlock_reg}, 16'h0001);
    speed_100 <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check({15'h0000, descr_bypass_reg}, 16'h0000);
    $display("override and line coding done");
    // toggle history and restart
    pulse_sent;
    check({15'h0000, np_word_reg[11]}, 16'h0000);
    pulse_sent;
    check({15'h0000, np_word_reg[11]}, 16'h0001);
    base_bit11 <= 1'b1;
    np_restart <= 1'b1;
    @(posedge sys_clk);
    np_restart <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check({15'h0000, np_word_reg[11]}, 16'h0000);
    $display("toggle done");
    // software reset keeps the address even with new straps
    pins <= 5'h15;
    sw_reset <= 1'b1;
    @(posedge sys_clk);
    sw_reset <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rdr(5'h10, 16'h0008);
    check({15'h0000, descr_unlock_reg}, 16'h0000);
    // another address is never answered, so the wire stays high
    i_mgmt_station.frame(2'h2, phy ^ 5'h01, 5'h10, 16'h0000, rd);
    check(rd, 16'hffff);
    rst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    phy = 5'h15;
    repeat (3) @(posedge sys_clk);
    rdr(5'h10, 16'h0008);
    $display("reset kinds done");
    wrap_up;
  end

  // hang guard, well beyond the expected run of about 11000 clocks
  initial begin
    repeat (40000) @(posedge sys_clk);
    n_fail = n_fail + 1;
    wrap_up;
  end
endmodule // next_page_and_extended_control_regs_bench
